//--- inc/nand_host_pkg.sv
// types shared by the nand host sequencer and its bench
package nand_host_pkg;

	typedef enum logic [2:0] {
		K_CMD, K_ADDR, K_DIN, K_DOUT, K_WAIT, K_DESEL
	} kind_t;

	typedef struct packed {
		kind_t      kind;
		logic [7:0] data;
	} req_t;

	typedef struct packed {
		logic [7:0] data;
		logic       timeout;
	} resp_t;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
	} pins_t;

	typedef enum logic [1:0] {CL_NONE, CL_READ, CL_PE} opcls_t;

endpackage : nand_host_pkg

//--- inc/nand_host_regs.svh
// command codes and bus timing counts for the nand host sequencer
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ************************************
// command codes
// ************************************
`define NH_C_READ      8'h00
`define NH_C_READ_GO   8'h30
`define NH_C_RDOUT     8'h05
`define NH_C_RDOUT_GO  8'he0
`define NH_C_CACHE_RD  8'h31
`define NH_C_CACHE_END 8'h3f
`define NH_C_ID        8'h90
`define NH_C_PARAM     8'hec
`define NH_C_UID       8'hed
`define NH_C_SETFEAT   8'hef
`define NH_C_GETFEAT   8'hee
`define NH_C_RESET     8'hff
`define NH_C_PROG      8'h80
`define NH_C_PROG2     8'h81
`define NH_C_PROG_GO   8'h10
`define NH_C_CPROG_GO  8'h15
`define NH_C_PLANE_GO  8'h11
`define NH_C_RNDIN     8'h85
`define NH_C_ERASE     8'h60
`define NH_C_ERASE_GO  8'hd0
`define NH_C_ERASE_PL  8'hd1
`define NH_C_STATUS    8'h70
`define NH_C_STATUS_EN 8'h78
`define NH_C_PROT      8'h7a

// ************************************
// timing, figures in ns or us, counts in 25 ns cycles
// ************************************
`define NH_CLK_NS      25
`define NH_T_ADL_NS    70
`define NH_T_WHR_NS    60
`define NH_T_RHW_NS    60
`define NH_T_WW_NS     100
`define NH_T_WB_NS     100
`define NH_T_R_US      25
`define NH_T_DBSY_US   1
`define NH_T_RST_I_US  5
`define NH_T_RST_R_US  10
`define NH_C_ADL       ((`NH_T_ADL_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_C_WHR       ((`NH_T_WHR_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_C_RHW       ((`NH_T_RHW_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_C_WW        ((`NH_T_WW_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_C_WB        (((`NH_T_WB_NS + `NH_CLK_NS - 1) / `NH_CLK_NS) + 2)
`define NH_C_R         ((`NH_T_R_US * 1000) / `NH_CLK_NS)
`define NH_C_DBSY      ((`NH_T_DBSY_US * 1000) / `NH_CLK_NS)
`define NH_C_RST_I     ((`NH_T_RST_I_US * 1000) / `NH_CLK_NS)
`define NH_C_RST_R     ((`NH_T_RST_R_US * 1000) / `NH_CLK_NS)
`define NH_C_RE_LOW    3
`define NH_TMR_W       18

`endif

//--- rtl/nand_host.sv
// nand flash host: turns queued bus cycles into strobes on the flash pins
//
// Overview of operation
// (R1) WE# rise classifies cmd, addr, data cycles
// (R2) write-mode commands only with WP# high
// (R3) write-mode address cycles need WP# high
// (R4) each RE# falling strobe fetches next byte
// (R5) WP# low inhibits; settle 100 ns first
// (R6) read, random out, cache read sequences
// (R7) page read busy at most 25 us
// (R8) reset anytime; done in 5/10/500 us
// (R9) status 70h/78h allowed while busy
// (R10) protection status 7Ah only when ready
// (R11) id, parameter, uid, feature commands accepted
// (R12) single-plane program, cache, erase, random input
// (R13) onfi two-plane program uses 80h twice
// (R14) onfi two-plane erase uses D1h then D0h
// (R15) traditional two-plane uses 81h or 60h-60h
// (R16) undefined command codes are never issued
// (R17) ready/busy only pulled low; pulled up outside
// (R18) ready/busy low for whole operation
// (R19) 70 ns from last address to data
// (R20) two-plane intermediate busy at most 1 us
// (R21) no commands until ready or 1 ms
// (R22) chip disabled ignores strobes: standby
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.svh"

module nand_host #(
	parameter int POR_CYCLES    = 40000,
	parameter int RST_PE_CYCLES = 20000,
	parameter int PE_CYCLES     = 140000
) (
	// clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	// user request stream
	input  wire logic                  req_valid_in,
	output logic                       req_ready_out,
	input  wire nand_host_pkg::req_t   req_in,
	input  wire logic                  wp_allow_in,
	// user answers
	output logic                       resp_valid_out,
	output nand_host_pkg::resp_t       resp_out,
	output logic                       refused_out,
	output logic                       flash_busy_out,
	// flash pins
	output nand_host_pkg::pins_t       pins_out,
	input  wire logic [7:0]            dq_in,
	output logic [7:0]                 dq_out,
	output logic                       dq_oe_out,
	input  wire logic                  rb_n_in
);

	// ************************************
	// command classes
	// ************************************
	function automatic logic cmd_legal(input logic [7:0] c);
		unique case (c)
			`NH_C_READ, `NH_C_READ_GO, `NH_C_RDOUT, `NH_C_RDOUT_GO, `NH_C_CACHE_RD,
			`NH_C_CACHE_END, `NH_C_ID, `NH_C_PARAM, `NH_C_UID, `NH_C_SETFEAT,
			`NH_C_GETFEAT, `NH_C_RESET, `NH_C_PROG, `NH_C_PROG2, `NH_C_PROG_GO,
			`NH_C_CPROG_GO, `NH_C_PLANE_GO, `NH_C_RNDIN, `NH_C_ERASE, `NH_C_ERASE_GO,
			`NH_C_ERASE_PL, `NH_C_STATUS, `NH_C_STATUS_EN, `NH_C_PROT: cmd_legal = 1'b1;
			default: cmd_legal = 1'b0;
		endcase
	endfunction : cmd_legal

	function automatic logic cmd_write(input logic [7:0] c);
		unique case (c)
			`NH_C_PROG, `NH_C_PROG2, `NH_C_PROG_GO, `NH_C_CPROG_GO, `NH_C_PLANE_GO,
			`NH_C_RNDIN, `NH_C_ERASE, `NH_C_ERASE_GO, `NH_C_ERASE_PL: cmd_write = 1'b1;
			default: cmd_write = 1'b0;
		endcase
	endfunction : cmd_write

	function automatic logic cmd_busy_ok(input logic [7:0] c);
		cmd_busy_ok = (c == `NH_C_RESET) || (c == `NH_C_STATUS) || (c == `NH_C_STATUS_EN);
	endfunction : cmd_busy_ok

	typedef enum logic [3:0] {
		S_POR, S_IDLE, S_WE_LO, S_WE_HI, S_WB, S_RE_LO, S_RE_HI, S_WAIT
	} state_t;

	// ************************************
	// pin synchronisers
	// ************************************
	logic [7:0] dq_s1_q, dq_s2_q;
	logic       rb_s1_q, rb_s2_q;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= rb_n_in;
			rb_s2_q <= rb_s1_q;
		end
	end

	// device only pulls the line low; a released line reads high via the board pull-up
	wire busy = !rb_s2_q; // R17 R18

	// ************************************
	// sequencer
	// ************************************
	state_t                      st_q, st_d;
	logic [`NH_TMR_W-1:0]        tmr_q, tmr_d, lim_q, lim_d;
	logic [2:0]                  gap_q, gap_d, wpc_q, wpc_d;
	nand_host_pkg::pins_t        pin_q, pin_d;
	logic [7:0]                  dq_q, dq_d;
	logic                        oe_q, oe_d, wmode_q, wmode_d;
	logic                        rv_q, rv_d, ref_q, ref_d;
	nand_host_pkg::resp_t        rsp_q, rsp_d;
	nand_host_pkg::opcls_t       cls_q, cls_d;
	logic                        we_kind, needs_wp, can_go;

	always_comb begin
		we_kind  = req_in.kind inside {nand_host_pkg::K_CMD, nand_host_pkg::K_ADDR,
		                              nand_host_pkg::K_DIN};
		needs_wp = (req_in.kind == nand_host_pkg::K_CMD && cmd_write(req_in.data)) // R2
		        || (req_in.kind == nand_host_pkg::K_ADDR && wmode_q) // R3
		        || (req_in.kind == nand_host_pkg::K_DIN); // R5
		can_go   = (gap_q == 3'h0)
		        && (!we_kind || (wpc_q == 3'h0 && wp_allow_in == pin_q.wp_n)); // R5 R19
		// while busy only reset, status reads, waits and deselects may go out; the rest waits
		if (busy && req_in.kind != nand_host_pkg::K_WAIT && req_in.kind != nand_host_pkg::K_DESEL
		    && !(req_in.kind == nand_host_pkg::K_CMD && cmd_busy_ok(req_in.data)))
			can_go = 1'b0; // R9 R10
		req_ready_out = (st_q == S_IDLE) && can_go;
	end

	always_comb begin
		st_d    = st_q;
		tmr_d   = tmr_q;
		lim_d   = lim_q;
		gap_d   = (gap_q != 3'h0) ? gap_q - 3'h1 : 3'h0;
		wpc_d   = (wpc_q != 3'h0) ? wpc_q - 3'h1 : 3'h0;
		pin_d   = pin_q;
		dq_d    = dq_q;
		oe_d    = oe_q;
		wmode_d = wmode_q;
		rv_d    = 1'b0;
		ref_d   = 1'b0;
		rsp_d   = rsp_q;
		cls_d   = cls_q;
		// never move wp in the cycle before a write strobe rises
		if (st_q != S_WE_LO)
			pin_d.wp_n = wp_allow_in;
		if (wp_allow_in != pin_q.wp_n)
			wpc_d = 3'(`NH_C_WW); // R5
		unique case (st_q)
			S_POR: begin
				tmr_d = tmr_q + 1'b1;
				if (tmr_q == `NH_TMR_W'(POR_CYCLES) || (tmr_q > `NH_TMR_W'(4) && !busy))
					st_d = S_IDLE; // R21
			end
			S_IDLE: begin
				if (req_valid_in && req_ready_out) begin
					pin_d.ce_n = 1'b0;
					tmr_d = '0;
					unique case (req_in.kind)
						nand_host_pkg::K_CMD, nand_host_pkg::K_ADDR, nand_host_pkg::K_DIN: begin
							if ((req_in.kind == nand_host_pkg::K_CMD && !cmd_legal(req_in.data))
							    || (needs_wp && !pin_q.wp_n)) begin
								ref_d = 1'b1; // R16 R2 R3 R5
								pin_d.ce_n = pin_q.ce_n;
							end else begin
								pin_d.cle  = req_in.kind == nand_host_pkg::K_CMD; // R1
								pin_d.ale  = req_in.kind == nand_host_pkg::K_ADDR; // R1
								pin_d.we_n = 1'b0;
								dq_d = req_in.data;
								oe_d = 1'b1;
								st_d = S_WE_LO;
							end
						end
						nand_host_pkg::K_DOUT: begin
							pin_d.re_n = 1'b0; // R4
							st_d = S_RE_LO;
						end
						nand_host_pkg::K_WAIT: st_d = S_WAIT;
						nand_host_pkg::K_DESEL: pin_d.ce_n = 1'b1; // R22
						default: ;
					endcase
				end
			end
			S_WE_LO: begin
				pin_d.we_n = 1'b1;
				st_d = S_WE_HI;
			end
			S_WE_HI: begin
				oe_d = 1'b0;
				pin_d.cle = 1'b0;
				pin_d.ale = 1'b0;
				gap_d = pin_q.ale ? 3'(`NH_C_ADL) : 3'(`NH_C_WHR); // R19
				st_d = S_IDLE;
				if (pin_q.cle) begin
					tmr_d = '0;
					st_d = S_WB;
					if (cmd_write(dq_q))
						wmode_d = 1'b1;
					else if (!cmd_busy_ok(dq_q) || dq_q == `NH_C_RESET)
						wmode_d = 1'b0;
					unique case (dq_q)
						`NH_C_READ_GO, `NH_C_CACHE_RD, `NH_C_CACHE_END: begin
							lim_d = `NH_TMR_W'(`NH_C_R); // R6 R7
							cls_d = nand_host_pkg::CL_READ;
						end
						`NH_C_PLANE_GO, `NH_C_ERASE_PL: begin
							lim_d = `NH_TMR_W'(`NH_C_DBSY); // R13 R14 R15 R20
							cls_d = nand_host_pkg::CL_PE;
						end
						`NH_C_PROG_GO, `NH_C_CPROG_GO, `NH_C_ERASE_GO: begin
							lim_d = `NH_TMR_W'(PE_CYCLES); // R12
							cls_d = nand_host_pkg::CL_PE;
						end
						`NH_C_RESET: begin
							if (!busy)
								lim_d = `NH_TMR_W'(`NH_C_RST_I); // R8
							else if (cls_q == nand_host_pkg::CL_PE)
								lim_d = `NH_TMR_W'(RST_PE_CYCLES); // R8
							else
								lim_d = `NH_TMR_W'(`NH_C_RST_R); // R8
						end
						`NH_C_SETFEAT, `NH_C_GETFEAT: lim_d = `NH_TMR_W'(`NH_C_DBSY); // R11
						default: ;
					endcase
				end
			end
			S_WB: begin
				tmr_d = tmr_q + 1'b1;
				if (tmr_q == `NH_TMR_W'(`NH_C_WB - 1))
					st_d = S_IDLE;
			end
			S_RE_LO: begin
				tmr_d = tmr_q + 1'b1;
				// held low long enough for access time plus the two sync stages
				if (tmr_q == `NH_TMR_W'(`NH_C_RE_LOW - 1)) begin
					pin_d.re_n = 1'b1;
					rsp_d.data = dq_s2_q; // R4
					rsp_d.timeout = 1'b0;
					rv_d = 1'b1;
					st_d = S_RE_HI;
				end
			end
			S_RE_HI: begin
				gap_d = 3'(`NH_C_RHW);
				st_d = S_IDLE;
			end
			S_WAIT: begin
				tmr_d = tmr_q + 1'b1;
				if (!busy || tmr_q == lim_q) begin
					rsp_d.timeout = busy; // R7 R8 R18 R20
					rv_d = 1'b1;
					cls_d = busy ? cls_q : nand_host_pkg::CL_NONE;
					st_d = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_q    <= S_POR;
			tmr_q   <= '0;
			lim_q   <= '0;
			gap_q   <= 3'h0;
			wpc_q   <= 3'h0;
			pin_q   <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
			dq_q    <= 8'h00;
			oe_q    <= 1'b0;
			wmode_q <= 1'b0;
			rv_q    <= 1'b0;
			ref_q   <= 1'b0;
			rsp_q   <= '0;
			cls_q   <= nand_host_pkg::CL_NONE;
		end else begin
			st_q    <= st_d;
			tmr_q   <= tmr_d;
			lim_q   <= lim_d;
			gap_q   <= gap_d;
			wpc_q   <= wpc_d;
			pin_q   <= pin_d;
			dq_q    <= dq_d;
			oe_q    <= oe_d;
			wmode_q <= wmode_d;
			rv_q    <= rv_d;
			ref_q   <= ref_d;
			rsp_q   <= rsp_d;
			cls_q   <= cls_d;
		end
	end

	assign pins_out       = pin_q;
	assign dq_out         = dq_q;
	assign dq_oe_out      = oe_q;
	assign resp_valid_out = rv_q;
	assign resp_out       = rsp_q;
	assign refused_out    = ref_q;
	assign flash_busy_out = busy;

	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	a_we_pulse_class: assert property ($fell(pin_q.we_n) |-> !pin_q.ce_n && pin_q.re_n // R1
		&& !(pin_q.cle && pin_q.ale) ##1 pin_q.we_n) else $error("bad write strobe");
	a_wp_cmd_gate: assert property (!pin_q.we_n && pin_q.cle && cmd_write(dq_q) // R2
		|-> pin_q.wp_n) else $error("write command with wp low");
	a_wp_addr_gate: assert property (!pin_q.we_n && pin_q.ale && wmode_q // R3
		|-> pin_q.wp_n) else $error("write address with wp low");
	a_re_strobe_len: assert property ($fell(pin_q.re_n) |-> pin_q.we_n && !oe_q // R4
		&& !pin_q.cle && !pin_q.ale ##0 (!pin_q.re_n)[*3] ##1 pin_q.re_n)
		else $error("bad read strobe");
	a_wp_settle_time: assert property ($changed(pin_q.wp_n) |-> pin_q.we_n[*5]) // R5
		else $error("wp changed too close to write strobe");
	a_adl_spacing: assert property ($rose(pin_q.we_n) && pin_q.ale // R19
		|-> pin_q.we_n[*5]) else $error("data too soon after address");
	a_legal_code: assert property (!pin_q.we_n && pin_q.cle |-> cmd_legal(dq_q)) // R16
		else $error("undefined command issued");
	a_busy_cmd_only: assert property (!pin_q.we_n && pin_q.cle && busy // R9
		|-> cmd_busy_ok(dq_q)) else $error("command while busy");
	a_por_quiet: assert property (st_q == S_POR |-> pin_q.we_n && pin_q.re_n) // R21
		else $error("strobe during power-on wait");
	a_standby_idle: assert property (pin_q.ce_n |-> pin_q.we_n && pin_q.re_n) // R22
		else $error("strobe while deselected");
	a_wait_bound: assert property (st_q == S_WAIT && tmr_q == lim_q |=> st_q == S_IDLE // R7
		&& resp_valid_out) else $error("busy wait overran its limit");

endmodule : nand_host
`default_nettype wire

//--- tb/nand_flash_model.sv
// behavioural flash device answering the host's pin strobes
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model #(
	parameter int POR_T  = 30,
	parameter int READ_T = 40,
	parameter int PROG_T = 50,
	parameter int RST_T  = 20,
	parameter int DBSY_T = 10
) (
	// clock
	input  wire logic                 clk_in,
	// host pins
	input  wire nand_host_pkg::pins_t pins_in,
	input  wire logic [7:0]           host_dq_in,
	output logic [7:0]                dq_out,
	output logic [7:0]                din_seen_out,
	output logic                      rb_n_out
);
	int                   busy_q = POR_T;
	logic                 por_q  = 1'b1;
	logic [7:0]           idx_q  = 8'h00;
	logic [7:0]           cur_q  = 8'h00;
	logic [7:0]           din_q  = 8'h00;
	logic [7:0]           gen_q  = 8'h00;
	logic [7:0]           seen_q = 8'h00;
	nand_host_pkg::pins_t prev_q = '1;
	logic                 cmd_edge;

	// ************************************
	// command decode
	// ************************************
	assign cmd_edge = !prev_q.we_n && pins_in.we_n && !pins_in.ce_n && pins_in.re_n;
	always @(posedge clk_in) begin
		prev_q <= pins_in;
		if (busy_q > 0) begin
			busy_q <= busy_q - 1;
		end else begin
			por_q <= 1'b0;
		end
		// data-input cycles only count with wp high
		if (cmd_edge && !pins_in.cle && !pins_in.ale && pins_in.wp_n)
			din_q <= host_dq_in;
		// only reset gets through while busy, nothing during power-on
		if (cmd_edge && pins_in.cle && !pins_in.ale
			&& (busy_q == 0 || (host_dq_in == 8'hff && !por_q))) begin
			case (host_dq_in)
				8'h30, 8'h31: begin
					busy_q <= READ_T;
					gen_q  <= gen_q + 8'h01;
				end
				8'h00, 8'h05, 8'he0, 8'h3f, 8'h90, 8'hec, 8'hed, 8'hee: gen_q <= gen_q + 8'h01;
				8'h10, 8'h15, 8'hd0: if (pins_in.wp_n) busy_q <= PROG_T;
				8'h11, 8'hd1, 8'hef: busy_q <= DBSY_T;
				8'hff: busy_q <= RST_T;
				default: ;
			endcase
		end
	end

	// ************************************
	// data out
	// ************************************
	always @(negedge pins_in.re_n) begin
		if (!pins_in.ce_n && pins_in.we_n && !pins_in.cle && !pins_in.ale) begin
			// a new read command restarts at the first byte
			if (seen_q != gen_q) begin
				seen_q = gen_q;
				idx_q  = 8'h00;
			end
			cur_q = idx_q ^ 8'h3c;
			idx_q = idx_q + 8'h01;
		end
	end
	// released bus shows the inverse so stale data never matches
	assign dq_out   = (!pins_in.ce_n && !pins_in.re_n) ? cur_q : ~cur_q;
	assign rb_n_out = (busy_q == 0);
	assign din_seen_out = din_q;
endmodule : nand_flash_model
`default_nettype wire

//--- tb/nand_host_tb.sv
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_host_tb;
	logic                 clk_sys_in = 1'b0;
	logic                 rst_in = 1'b1;
	logic                 req_valid_in = 1'b0;
	nand_host_pkg::req_t  req_in = '0;
	logic                 wp_allow_in = 1'b0;
	logic                 req_ready_out, resp_valid_out, refused_out, flash_busy_out;
	nand_host_pkg::resp_t resp_out, last_resp;
	nand_host_pkg::pins_t pins_out;
	logic [7:0]           dq_out, dev_dq, dq_wire, din_seen;
	logic                 dq_oe_out, rb_n;
	int                   miscompares = 0, total_checks = 0, n_ref = 0, got = 0;
	logic [31:0]          lfsr_q = 32'h34c8;
	logic [7:0]           cs [6] = '{8'h90, 8'hec, 8'hed, 8'hef, 8'hee, 8'h78};

	assign dq_wire = dq_oe_out ? dq_out : dev_dq;
	nand_host #(.POR_CYCLES(50), .RST_PE_CYCLES(30), .PE_CYCLES(60)) nand_host_inst (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
		.req_ready_out(req_ready_out), .req_in(req_in), .wp_allow_in(wp_allow_in),
		.resp_valid_out(resp_valid_out), .resp_out(resp_out), .refused_out(refused_out),
		.flash_busy_out(flash_busy_out), .pins_out(pins_out), .dq_in(dq_wire),
		.dq_out(dq_out), .dq_oe_out(dq_oe_out), .rb_n_in(rb_n));
	nand_flash_model nand_flash_model_inst (.clk_in(clk_sys_in), .pins_in(pins_out),
		.host_dq_in(dq_wire), .dq_out(dev_dq), .din_seen_out(din_seen), .rb_n_out(rb_n));

	initial forever #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		if (refused_out === 1'b1) n_ref++;
		if (resp_valid_out === 1'b1) begin
			got++;
			last_resp = resp_out;
		end
	end

	// ************************************
	// helpers
	// ************************************
	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_byte(input int i);
		return 8'(i) ^ 8'h3c;
	endfunction : exp_byte
	function automatic logic is_def(input logic [7:0] b);
		case (b)
			8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h3f, 8'h90, 8'hec, 8'hed, 8'hef, 8'hee,
			8'hff, 8'h80, 8'h81, 8'h10, 8'h15, 8'h11, 8'h85, 8'h60, 8'hd0, 8'hd1,
			8'h70, 8'h78, 8'h7a: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_def
	task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask : cmp8
	task automatic cmp1(input string what, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", what, e, s);
		end
	endtask : cmp1
	task automatic send(input nand_host_pkg::kind_t k, input logic [7:0] d);
		int n;
		@(posedge clk_sys_in);
		#2;
		req_in = '{kind: k, data: d};
		req_valid_in = 1'b1;
		for (n = 0; n < 3000; n++) begin
			@(negedge clk_sys_in);
			if (req_ready_out === 1'b1) break;
		end
		@(posedge clk_sys_in);
		#2;
		req_valid_in = 1'b0;
		cmp1("request taken", 1'b1, n < 3000);
	endtask : send
	task automatic fetch(input nand_host_pkg::kind_t k, output nand_host_pkg::resp_t r);
		int g, n;
		g = got;
		send(k, 8'h00);
		for (n = 0; n < 3000 && got == g; n++) @(posedge clk_sys_in);
		#1;
		r = last_resp;
		cmp1("response seen", 1'b1, got != g);
	endtask : fetch
	task automatic settle();
		nand_host_pkg::resp_t r;
		fetch(nand_host_pkg::K_WAIT, r);
		cmp1("wait timeout", 1'b0, r.timeout);
	endtask : settle
	task automatic try_ref(input nand_host_pkg::kind_t k, input logic [7:0] d, input logic e);
		int c;
		c = n_ref;
		send(k, d);
		repeat (3) @(posedge clk_sys_in);
		cmp1("refused", e, n_ref != c);
	endtask : try_ref
	task automatic read_bytes(input int n);
		nand_host_pkg::resp_t r;
		for (int i = 0; i < n; i++) begin
			fetch(nand_host_pkg::K_DOUT, r);
			cmp8("read byte", exp_byte(i), r.data);
		end
	endtask : read_bytes
	task automatic plane(input logic [7:0] c1, input logic [7:0] c2, input int na);
		logic [7:0] b;
		logic       load;
		load = (c1 == 8'h80) || (c1 == 8'h81);
		send(nand_host_pkg::K_CMD, c1);
		for (int i = 0; i < na; i++) begin
			b = rnd();
			send(nand_host_pkg::K_ADDR, b);
		end
		// only program loads carry data; reads go straight to their confirm
		if (load) begin
			b = rnd();
			send(nand_host_pkg::K_DIN, b);
			send(nand_host_pkg::K_CMD, 8'h85);
			send(nand_host_pkg::K_ADDR, b);
			send(nand_host_pkg::K_DIN, ~b);
		end
		send(nand_host_pkg::K_CMD, c2);
		settle();
		if (load)
			cmp8("data latched", ~b, din_seen);
	endtask : plane
	task automatic set_wp(input logic v);
		@(posedge clk_sys_in);
		#2;
		wp_allow_in = v;
	endtask : set_wp
	task automatic close_out();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// ************************************
	// scenarios
	// ************************************
	initial begin
		logic [7:0] b;
		repeat (10) @(posedge clk_sys_in);
		#2;
		rst_in = 1'b0;
		cmp1("ce_n after reset", 1'b1, pins_out.ce_n);
		cmp1("wp_n after reset", 1'b0, pins_out.wp_n);
		cmp1("ready during power-on", 1'b0, req_ready_out);
		for (int i = 0; i < 8; i++) begin
			b = rnd();
			b = (i == 0) ? 8'h7b : (i == 1) ? 8'hfe : (is_def(b) ? 8'h01 : b);
			try_ref(nand_host_pkg::K_CMD, b, 1'b1);
		end
		try_ref(nand_host_pkg::K_CMD, 8'h80, 1'b1);
		try_ref(nand_host_pkg::K_CMD, 8'h00, 1'b0);
		try_ref(nand_host_pkg::K_ADDR, 8'h12, 1'b0);
		for (int g = 0; g < 2; g++) begin
			plane(8'h00, g ? 8'h31 : 8'h30, 5);
			read_bytes(2 + g * 2);
		end
		send(nand_host_pkg::K_CMD, 8'h31);
		settle();
		read_bytes(3);
		send(nand_host_pkg::K_CMD, 8'h3f);
		plane(8'h05, 8'he0, 2);
		read_bytes(2);
		set_wp(1'b1);
		plane(8'h80, 8'h10, 5);
		plane(8'h80, 8'h15, 5);
		plane(8'h80, 8'h11, 5);
		plane(8'h80, 8'h10, 5);
		plane(8'h80, 8'h11, 5);
		plane(8'h81, 8'h15, 5);
		plane(8'h60, 8'hd1, 3);
		plane(8'h60, 8'h60, 3);
		plane(8'h60, 8'hd0, 3);
		set_wp(1'b0);
		try_ref(nand_host_pkg::K_ADDR, 8'h21, 1'b1);
		try_ref(nand_host_pkg::K_DIN, 8'h21, 1'b1);
		set_wp(1'b1);
		send(nand_host_pkg::K_CMD, 8'hd0);
		repeat (12) @(posedge clk_sys_in);
		#2;
		cmp1("busy during erase", 1'b1, flash_busy_out);
		req_in = '{kind: nand_host_pkg::K_CMD, data: 8'h7a};
		@(negedge clk_sys_in);
		cmp1("ready for 7a while busy", 1'b0, req_ready_out);
		send(nand_host_pkg::K_CMD, 8'h70);
		cmp1("busy after status", 1'b1, flash_busy_out);
		send(nand_host_pkg::K_CMD, 8'hff);
		settle();
		send(nand_host_pkg::K_DESEL, 8'h00);
		cmp1("ce_n after deselect", 1'b1, pins_out.ce_n);
		try_ref(nand_host_pkg::K_CMD, 8'h7a, 1'b0);
		foreach (cs[i]) begin
			try_ref(nand_host_pkg::K_CMD, cs[i], 1'b0);
			send(nand_host_pkg::K_ADDR, 8'h00);
			settle();
		end
		// second reset in mid-run: pins safe again and power-on wait redone
		@(posedge clk_sys_in);
		#2;
		rst_in = 1'b1;
		@(posedge clk_sys_in);
		#2;
		rst_in = 1'b0;
		cmp1("wp_n after mid reset", 1'b0, pins_out.wp_n);
		cmp1("ready after mid reset", 1'b0, req_ready_out);
		try_ref(nand_host_pkg::K_CMD, 8'h90, 1'b0);
		close_out();
	end
	initial begin
		#(25.0 * 60000);
		miscompares++;
		close_out();
	end
endmodule : nand_host_tb
`default_nettype wire
